/* branch_cond.sv */
// branch condition evaluator
`timescale 1ns/10ps
`default_nettype none
module branch_cond
  import branch_pkg::*;
(
  input  wire branch_kind_t kind_in,
  input  wire logic         carry_in,
  input  wire logic         zero_in,
  input  wire logic         bit_in,
  output logic              taken_out
);

  always_comb begin
    case (kind_in)
      KIND_TAC:   taken_out = bit_in;
      KIND_BSET:  taken_out = bit_in;
      KIND_CARRY: taken_out = carry_in;
      KIND_EQUAL: taken_out = zero_in;
      KIND_ABOVE: taken_out = !zero_in && !carry_in;
      KIND_BELOW: taken_out = zero_in || carry_in;
      default:    taken_out = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* branch_decode.sv */
// first-byte decoder of the branch group
`timescale 1ns/10ps
`default_nettype none
module branch_decode
  import branch_pkg::*;
(
  input  wire logic   [7:0] opcode_in,
  input  wire logic         prefixed_in,
  input  wire logic         src_mode_in,
  output logic              valid_out,
  output logic              escape_out,
  output logic              long_out,
  output branch_kind_t      kind_out,
  output logic        [1:0] ops_out
);

  logic ext_ok;

  always_comb begin
    // extended opcodes need the escape in binary mode and none in source mode
    ext_ok     = src_mode_in ? !prefixed_in : prefixed_in;
    valid_out  = 1'b0;
    escape_out = !src_mode_in && !prefixed_in && (opcode_in == OP_ESCAPE);
    long_out   = 1'b0;
    kind_out   = KIND_TAC;
    ops_out    = OPS_REL;
    case (opcode_in)
      OP_TAC_SHORT: begin
        valid_out = !prefixed_in;
        ops_out   = OPS_BIT;
      end
      OP_BSET_SHORT: begin
        valid_out = !prefixed_in;
        kind_out  = KIND_BSET;
        ops_out   = OPS_BIT;
      end
      OP_CARRY: begin
        valid_out = !prefixed_in;
        kind_out  = KIND_CARRY;
      end
      OP_EQUAL: begin
        valid_out = ext_ok;
        kind_out  = KIND_EQUAL;
      end
      OP_ABOVE: begin
        valid_out = ext_ok;
        kind_out  = KIND_ABOVE;
      end
      OP_BELOW: begin
        valid_out = ext_ok;
        kind_out  = KIND_BELOW;
      end
      OP_BIT_LONG: begin
        valid_out = ext_ok;
        long_out  = 1'b1;
        ops_out   = OPS_BIT;
      end
      default: begin
        valid_out = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

/* branch_pkg.sv */
// constants, types and timing tables of the conditional branch unit
package branch_pkg;

  typedef enum logic [2:0] {
    KIND_TAC,
    KIND_BSET,
    KIND_CARRY,
    KIND_EQUAL,
    KIND_ABOVE,
    KIND_BELOW
  } branch_kind_t;

  typedef enum {
    S_IDLE,
    S_PREFIX,
    S_SUBOP,
    S_OPER,
    S_EXEC
  } fsm_t;

  // opcodes
  localparam logic [7:0] OP_ESCAPE     = 8'ha5;
  localparam logic [7:0] OP_BIT_LONG   = 8'ha9;
  localparam logic [7:0] OP_TAC_SHORT  = 8'h10;
  localparam logic [7:0] OP_BSET_SHORT = 8'h20;
  localparam logic [7:0] OP_CARRY      = 8'h40;
  localparam logic [7:0] OP_EQUAL      = 8'h68;
  localparam logic [7:0] OP_ABOVE      = 8'h38;
  localparam logic [7:0] OP_BELOW      = 8'h28;

  // long-form sub-opcode: upper nibble, then a zero bit, then the bit position
  localparam logic [3:0] SUB_TAC       = 4'h1;
  localparam logic [3:0] SUB_BSET      = 4'h2;
  localparam int         SUB_NIB_LSB   = 4;
  localparam int         SUB_ZERO_BIT  = 3;

  // operand bytes after the opcode (long form: after the sub-opcode)
  localparam logic [1:0] OPS_BIT       = 2'h2;
  localparam logic [1:0] OPS_REL       = 2'h1;

  // state counts, not taken / taken
  localparam logic [2:0] ST_TAC_SHORT_NT  = 3'h4;
  localparam logic [2:0] ST_TAC_SHORT_T   = 3'h7;
  localparam logic [2:0] ST_BSET_SHORT_NT = 3'h2;
  localparam logic [2:0] ST_BSET_SHORT_T  = 3'h5;
  localparam logic [2:0] ST_LONG_BIN_NT   = 3'h4;
  localparam logic [2:0] ST_LONG_BIN_T    = 3'h7;
  localparam logic [2:0] ST_LONG_SRC_NT   = 3'h3;
  localparam logic [2:0] ST_LONG_SRC_T    = 3'h6;
  localparam logic [2:0] ST_CARRY_NT      = 3'h1;
  localparam logic [2:0] ST_CARRY_T       = 3'h4;
  localparam logic [2:0] ST_COND_BIN_NT   = 3'h2;
  localparam logic [2:0] ST_COND_BIN_T    = 3'h5;
  localparam logic [2:0] ST_COND_SRC_NT   = 3'h1;
  localparam logic [2:0] ST_COND_SRC_T    = 3'h4;
  localparam logic [2:0] CNT_FIRST        = 3'h1;

  localparam int PC_W_DEFAULT = 24;

  function automatic logic is_bit_kind(input branch_kind_t kind);
    is_bit_kind = (kind == KIND_TAC) || (kind == KIND_BSET);
  endfunction

  // total states of one branch
  function automatic logic [2:0] states_for(input branch_kind_t kind, input logic long_form,
                                            input logic src_mode, input logic taken);
    logic [2:0] nt;
    logic [2:0] tk;
    nt = src_mode ? ST_COND_SRC_NT : ST_COND_BIN_NT;
    tk = src_mode ? ST_COND_SRC_T : ST_COND_BIN_T;
    if (long_form) begin
      nt = src_mode ? ST_LONG_SRC_NT : ST_LONG_BIN_NT;
      tk = src_mode ? ST_LONG_SRC_T : ST_LONG_BIN_T;
    end else if (kind == KIND_TAC) begin
      nt = ST_TAC_SHORT_NT;
      tk = ST_TAC_SHORT_T;
    end else if (kind == KIND_BSET) begin
      nt = ST_BSET_SHORT_NT;
      tk = ST_BSET_SHORT_T;
    end else if (kind == KIND_CARRY) begin
      nt = ST_CARRY_NT;
      tk = ST_CARRY_T;
    end
    states_for = taken ? tk : nt;
  endfunction

endpackage

/* conditional_branch_unit.sv */
// fetch, decode and execution of the conditional relative branch group
`timescale 1ns/10ps
`default_nettype none
// Function
// - test-and-clear: bit one branches and clears it
// - test-and-clear never writes an already-zero bit
// - bit branches: next pc plus last-byte displacement
// - test-and-clear reads port bits from latch
// - short test-and-clear: 0x10, 3 bytes, 4/7
// - long test-and-clear: 5/4 bytes, 4/7 or 3/6
// - extended opcodes need escape only in binary
// - two-byte jumps: next pc plus sign-extended displacement
// - carry branch: 0x40, 2 bytes, 1/4 states
// - equal branch on zero flag, 0x68
// - above branch: zero and carry clear, 0x38
// - below-or-same: zero or carry set, 0x28
// - bit-set branch leaves tested bit unchanged
module conditional_branch_unit
  import branch_pkg::*;
#(
  parameter int PC_W = PC_W_DEFAULT
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            src_mode_in,
  input  wire logic            byte_valid_in,
  input  wire logic [7:0]      byte_in,
  output logic                 byte_ready_out,
  input  wire logic            carry_flag_in,
  input  wire logic            zero_flag_in,
  input  wire logic            pc_load_in,
  input  wire logic [PC_W-1:0] pc_load_value_in,
  output logic      [PC_W-1:0] pc_out,
  output logic                 busy_out,
  output logic                 done_out,
  output logic                 taken_out,
  output logic                 unknown_out,
  output logic                 bit_rd_req_out,
  output logic                 bit_latch_out,
  output logic                 bit_long_out,
  output logic      [7:0]      bit_addr_out,
  output logic      [2:0]      bit_pos_out,
  input  wire logic            bit_rd_data_in,
  output logic                 bit_clr_out
);

  localparam logic [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};

  fsm_t               state_q, state_d;
  branch_kind_t       kind_q, kind_d;
  logic               long_q, long_d;
  logic               src_q, src_d;
  logic [1:0]         ops_q, ops_d;
  logic [1:0]         idx_q, idx_d;
  logic [2:0]         cnt_q, cnt_d;
  logic [PC_W-1:0]    pc_q, pc_d;
  logic [7:0]         addr_q, addr_d;
  logic [2:0]         pos_q, pos_d;
  logic [7:0]         rel_q, rel_d;
  logic               carry_q, carry_d;
  logic               zero_q, zero_d;
  logic               bit_q, bit_d;
  logic               esc_q, esc_d;

  logic               accept;
  logic               dec_valid;
  logic               dec_escape;
  logic               dec_long;
  branch_kind_t       dec_kind;
  logic [1:0]         dec_ops;
  logic               bit_now;
  logic               cond_taken;
  logic [2:0]         need;
  logic [PC_W-1:0]    rel_ext;
  logic [3:0]         sub_nib;

  branch_decode u_decode (
    .opcode_in   (byte_in),
    .prefixed_in (state_q == S_PREFIX),
    .src_mode_in (src_mode_in),
    .valid_out   (dec_valid),
    .escape_out  (dec_escape),
    .long_out    (dec_long),
    .kind_out    (dec_kind),
    .ops_out     (dec_ops)
  );

  // bit value is live on the first execution state and held afterwards
  assign bit_now = (cnt_q == CNT_FIRST) ? bit_rd_data_in : bit_q;

  branch_cond u_cond (
    .kind_in   (kind_q),
    .carry_in  (carry_q),
    .zero_in   (zero_q),
    .bit_in    (bit_now),
    .taken_out (cond_taken)
  );

  assign accept  = byte_valid_in && byte_ready_out;
  assign rel_ext = {{(PC_W-8){rel_q[7]}}, rel_q};
  assign need    = states_for(kind_q, long_q, src_q, cond_taken);
  assign sub_nib = byte_in[SUB_NIB_LSB +: 4];

  assign byte_ready_out = (state_q != S_EXEC);
  assign busy_out       = (state_q != S_IDLE);
  assign pc_out         = pc_q;
  assign bit_addr_out   = addr_q;
  assign bit_pos_out    = pos_q;
  assign bit_long_out   = long_q;
  assign taken_out      = done_out && cond_taken;

  always_comb begin
    state_d        = state_q;
    kind_d         = kind_q;
    long_d         = long_q;
    src_d          = src_q;
    ops_d          = ops_q;
    idx_d          = idx_q;
    cnt_d          = cnt_q;
    pc_d           = pc_q;
    addr_d         = addr_q;
    pos_d          = pos_q;
    rel_d          = rel_q;
    carry_d        = carry_q;
    zero_d         = zero_q;
    bit_d          = bit_q;
    esc_d          = esc_q;
    done_out       = 1'b0;
    unknown_out    = 1'b0;
    bit_rd_req_out = 1'b0;
    bit_latch_out  = 1'b0;
    bit_clr_out    = 1'b0;
    case (state_q)
      S_IDLE, S_PREFIX: begin
        if (accept) begin
          pc_d = pc_q + PC_ONE;
          if (state_q == S_IDLE) begin
            // flags as they stand before the instruction
            carry_d = carry_flag_in;
            zero_d  = zero_flag_in;
            src_d   = src_mode_in;
            esc_d   = 1'b0;
          end
          idx_d = 2'h0;
          if (dec_escape) begin
            esc_d   = 1'b1;
            state_d = S_PREFIX;
          end else if (dec_valid) begin
            kind_d  = dec_kind;
            long_d  = dec_long;
            ops_d   = dec_ops;
            state_d = dec_long ? S_SUBOP : S_OPER;
          end else begin
            unknown_out = 1'b1;
            state_d     = S_IDLE;
          end
        end
      end
      S_SUBOP: begin
        if (accept) begin
          pc_d  = pc_q + PC_ONE;
          pos_d = byte_in[2:0];
          if (byte_in[SUB_ZERO_BIT] == 1'b0 && sub_nib == SUB_TAC) begin
            kind_d  = KIND_TAC;
            state_d = S_OPER;
          end else if (byte_in[SUB_ZERO_BIT] == 1'b0 && sub_nib == SUB_BSET) begin
            kind_d  = KIND_BSET;
            state_d = S_OPER;
          end else begin
            unknown_out = 1'b1;
            state_d     = S_IDLE;
          end
        end
      end
      S_OPER: begin
        if (accept) begin
          pc_d = pc_q + PC_ONE;
          if (idx_q == 2'h0 && ops_q == OPS_BIT) begin
            addr_d = byte_in;
          end
          if (idx_q == ops_q - 2'h1) begin
            rel_d   = byte_in;
            cnt_d   = CNT_FIRST;
            state_d = S_EXEC;
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      S_EXEC: begin
        if (cnt_q == CNT_FIRST) begin
          bit_rd_req_out = is_bit_kind(kind_q);
          bit_latch_out  = (kind_q == KIND_TAC);
          bit_d          = bit_rd_data_in;
        end
        if (cnt_q == need) begin
          done_out = 1'b1;
          if (cond_taken) begin
            pc_d = pc_q + rel_ext;
          end
          bit_clr_out = cond_taken && (kind_q == KIND_TAC);
          state_d     = S_IDLE;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (pc_load_in) begin
      pc_d = pc_load_value_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      kind_q  <= KIND_TAC;
      long_q  <= 1'b0;
      src_q   <= 1'b0;
      ops_q   <= OPS_REL;
      idx_q   <= 2'h0;
      cnt_q   <= CNT_FIRST;
      pc_q    <= '0;
      addr_q  <= 8'h00;
      pos_q   <= 3'h0;
      rel_q   <= 8'h00;
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
      bit_q   <= 1'b0;
      esc_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      long_q  <= long_d;
      src_q   <= src_d;
      ops_q   <= ops_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      pc_q    <= pc_d;
      addr_q  <= addr_d;
      pos_q   <= pos_d;
      rel_q   <= rel_d;
      carry_q <= carry_d;
      zero_q  <= zero_d;
      bit_q   <= bit_d;
      esc_q   <= esc_d;
    end
  end

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence seq_bit_read;
    bit_rd_req_out && (kind_q == KIND_TAC);
  endsequence

  sequence seq_tac_cleared;
    done_out && taken_out && bit_clr_out;
  endsequence

  chk_clear_when_set: assert property (seq_bit_read ##0 bit_rd_data_in
                                       |-> ##[0:6] seq_tac_cleared)
    else $error("test-and-clear with bit set did not clear it");

  chk_no_clear_zero: assert property (done_out && !taken_out |-> !bit_clr_out)
    else $error("bit clear issued on a not-taken branch");

  chk_bit_target: assert property (done_out && taken_out && is_bit_kind(kind_q) && !pc_load_in
                                   |=> pc_out == $past(pc_q) + $past(rel_ext))
    else $error("bit branch target is not next pc plus displacement");

  chk_latch_read: assert property (seq_bit_read |-> bit_latch_out)
    else $error("test-and-clear read not taken from the output latch");

  chk_short_tac_time: assert property (done_out && kind_q == KIND_TAC && !long_q
                                       |-> cnt_q == (taken_out ? ST_TAC_SHORT_T : ST_TAC_SHORT_NT))
    else $error("short test-and-clear state count wrong");

  chk_long_tac_time: assert property (done_out && kind_q == KIND_TAC && long_q
                                      |-> cnt_q == (src_q ? (taken_out ? ST_LONG_SRC_T : ST_LONG_SRC_NT)
                                                          : (taken_out ? ST_LONG_BIN_T : ST_LONG_BIN_NT)))
    else $error("long test-and-clear state count wrong");

  chk_escape_needed: assert property (done_out && !src_q && (long_q || kind_q == KIND_EQUAL
                                      || kind_q == KIND_ABOVE || kind_q == KIND_BELOW) |-> esc_q)
    else $error("extended branch ran in binary mode without escape");

  chk_jump_target: assert property (done_out && !is_bit_kind(kind_q) && !pc_load_in
                                    |=> pc_out == $past(pc_q) + ($past(taken_out) ? $past(rel_ext) : '0))
    else $error("conditional jump pc update wrong");

  chk_carry_branch: assert property (done_out && kind_q == KIND_CARRY
                                     |-> taken_out == carry_q && cnt_q == (carry_q ? ST_CARRY_T : ST_CARRY_NT))
    else $error("carry branch decision or timing wrong");

  chk_equal_branch: assert property (done_out && kind_q == KIND_EQUAL |-> taken_out == zero_q)
    else $error("equal branch decision wrong");

  chk_above_branch: assert property (done_out && kind_q == KIND_ABOVE
                                     |-> taken_out == (!zero_q && !carry_q))
    else $error("above branch decision wrong");

  chk_below_branch: assert property (done_out && kind_q == KIND_BELOW
                                     |-> taken_out == (zero_q || carry_q))
    else $error("below-or-same branch decision wrong");

  chk_bset_no_clear: assert property (done_out && kind_q == KIND_BSET |-> !bit_clr_out)
    else $error("bit-set branch modified the tested bit");

  chk_flags_held: assert property (state_q == S_EXEC && cnt_q != CNT_FIRST
                                   |-> $stable(carry_q) && $stable(zero_q))
    else $error("entry flags changed during execution");

endmodule
`default_nettype wire

/* conditional_branch_unit_tb_top.sv */
// self-checking testbench of the conditional branch unit
`timescale 1ns/10ps
`default_nettype none
module conditional_branch_unit_tb_top;
  import branch_pkg::*;
  localparam int PCW = PC_W_DEFAULT;
  typedef struct packed {
    logic        src;
    logic [39:0] code;
    logic [2:0]  n;
    logic        carry;
    logic        zero;
    logic        bitv;
    logic [2:0]  states;
    logic        taken;
    logic        clr;
  } row_t;
  logic           clk_in;
  logic           rst_in;
  logic           src_mode_in;
  logic           byte_valid_in;
  logic [7:0]     byte_in;
  logic           byte_ready_out;
  logic           carry_flag_in;
  logic           zero_flag_in;
  logic           pc_load_in;
  logic [PCW-1:0] pc_load_value_in;
  logic [PCW-1:0] pc_out;
  logic           busy_out;
  logic           done_out;
  logic           taken_out;
  logic           unknown_out;
  logic           bit_rd_req_out;
  logic           bit_latch_out;
  logic           bit_long_out;
  logic [7:0]     bit_addr_out;
  logic [2:0]     bit_pos_out;
  logic           bit_rd_data_in;
  logic           bit_clr_out;
  logic [PCW-1:0] exp_pc;
  int             num_errors = 0;
  int             compares = 0;
  // src, bytes, count, carry, zero, bit, states, taken, clear
  row_t rows [18] = '{
    '{1'h0, 40'h1033050000, 3'h3, 1'h0, 1'h0, 1'h1, 3'h7, 1'h1, 1'h1},
    '{1'h1, 40'h1033fb0000, 3'h3, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 1'h0},
    '{1'h0, 40'h2044fe0000, 3'h3, 1'h0, 1'h0, 1'h1, 3'h5, 1'h1, 1'h0},
    '{1'h0, 40'h2044fe0000, 3'h3, 1'h0, 1'h0, 1'h0, 3'h2, 1'h0, 1'h0},
    '{1'h0, 40'ha5a91380f0, 3'h5, 1'h0, 1'h0, 1'h1, 3'h7, 1'h1, 1'h1},
    '{1'h1, 40'ha915801000, 3'h4, 1'h0, 1'h0, 1'h0, 3'h3, 1'h0, 1'h0},
    '{1'h1, 40'ha915801000, 3'h4, 1'h0, 1'h0, 1'h1, 3'h6, 1'h1, 1'h1},
    '{1'h0, 40'ha5a9229004, 3'h5, 1'h0, 1'h0, 1'h1, 3'h7, 1'h1, 1'h0},
    '{1'h0, 40'h407f000000, 3'h2, 1'h1, 1'h0, 1'h0, 3'h4, 1'h1, 1'h0},
    '{1'h1, 40'h4080000000, 3'h2, 1'h0, 1'h1, 1'h0, 3'h1, 1'h0, 1'h0},
    '{1'h0, 40'ha568800000, 3'h3, 1'h0, 1'h1, 1'h0, 3'h5, 1'h1, 1'h0},
    '{1'h1, 40'h6802000000, 3'h2, 1'h1, 1'h0, 1'h0, 3'h1, 1'h0, 1'h0},
    '{1'h0, 40'ha538100000, 3'h3, 1'h0, 1'h0, 1'h0, 3'h5, 1'h1, 1'h0},
    '{1'h1, 40'h3810000000, 3'h2, 1'h1, 1'h0, 1'h0, 3'h1, 1'h0, 1'h0},
    '{1'h1, 40'h3810000000, 3'h2, 1'h0, 1'h1, 1'h0, 3'h1, 1'h0, 1'h0},
    '{1'h0, 40'ha528f00000, 3'h3, 1'h1, 1'h0, 1'h0, 3'h5, 1'h1, 1'h0},
    '{1'h1, 40'h2810000000, 3'h2, 1'h0, 1'h1, 1'h0, 3'h4, 1'h1, 1'h0},
    '{1'h0, 40'ha528100000, 3'h3, 1'h0, 1'h0, 1'h0, 3'h2, 1'h0, 1'h0}
  };

  conditional_branch_unit #(.PC_W(PCW)) dut (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .src_mode_in      (src_mode_in),
    .byte_valid_in    (byte_valid_in),
    .byte_in          (byte_in),
    .byte_ready_out   (byte_ready_out),
    .carry_flag_in    (carry_flag_in),
    .zero_flag_in     (zero_flag_in),
    .pc_load_in       (pc_load_in),
    .pc_load_value_in (pc_load_value_in),
    .pc_out           (pc_out),
    .busy_out         (busy_out),
    .done_out         (done_out),
    .taken_out        (taken_out),
    .unknown_out      (unknown_out),
    .bit_rd_req_out   (bit_rd_req_out),
    .bit_latch_out    (bit_latch_out),
    .bit_long_out     (bit_long_out),
    .bit_addr_out     (bit_addr_out),
    .bit_pos_out      (bit_pos_out),
    .bit_rd_data_in   (bit_rd_data_in),
    .bit_clr_out      (bit_clr_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one byte offered at a falling edge, taken at the next rising edge
  task automatic send(input logic [7:0] b);
    chk(byte_ready_out, 1'b1, "ready in fetch");
    byte_valid_in = 1'b1;
    byte_in = b;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic run_row(input row_t r);
    logic [7:0] b [5];
    logic [7:0] op;
    logic [7:0] sub;
    logic [7:0] rel;
    logic       bitk;
    logic       tac;
    int         first;
    int         k;
    for (int i = 0; i < 5; i++) b[i] = r.code[39-8*i -: 8];
    first = (b[0] == OP_ESCAPE) ? 1 : 0;
    op = b[first];
    sub = b[first+1];
    bitk = (op == OP_TAC_SHORT) || (op == OP_BSET_SHORT) || (op == OP_BIT_LONG);
    tac = (op == OP_TAC_SHORT) || (op == OP_BIT_LONG && sub[7:4] == SUB_TAC);
    rel = b[r.n-1];
    src_mode_in = r.src;
    carry_flag_in = r.carry;
    zero_flag_in = r.zero;
    bit_rd_data_in = r.bitv;
    for (int i = 0; i < r.n; i++) begin
      send(b[i]);
      carry_flag_in = ~r.carry;
      zero_flag_in = ~r.zero;
    end
    byte_valid_in = 1'b0;
    chk(busy_out, 1'b1, "busy in execution");
    chk(byte_ready_out, 1'b0, "ready in execution");
    chk(bit_rd_req_out, bitk, "bit read request");
    if (bitk) begin
      chk(bit_latch_out, tac, "latch select");
      chk(bit_long_out, op == OP_BIT_LONG, "long form");
      chk(bit_addr_out, (op == OP_BIT_LONG) ? b[first+2] : b[first+1], "bit address");
      if (op == OP_BIT_LONG) chk(bit_pos_out, sub[2:0], "bit position");
    end
    k = 1;
    while (done_out !== 1'b1 && k < 9) begin
      chk(bit_clr_out, 1'b0, "early clear");
      @(negedge clk_in);
      bit_rd_data_in = ~r.bitv;
      k++;
    end
    chk(k, r.states, "state count");
    chk(taken_out, r.taken, "taken");
    chk(bit_clr_out, r.clr, "bit clear");
    exp_pc = exp_pc + r.n + (r.taken ? {{(PCW-8){rel[7]}}, rel} : '0);
    @(negedge clk_in);
    chk(pc_out, exp_pc, "next pc");
  endtask

  // a byte the decoder rejects in the given mode, optionally after an escape
  task automatic bad(input logic src, input logic pre, input logic [7:0] b0);
    logic seen;
    src_mode_in = src;
    if (pre) send(OP_ESCAPE);
    byte_valid_in = 1'b1;
    byte_in = b0;
    #1 seen = unknown_out;
    @(posedge clk_in);
    @(negedge clk_in);
    exp_pc = exp_pc + (pre ? 2 : 1);
    chk(seen, 1'b1, "unknown flagged");
    chk(busy_out, 1'b0, "idle after unknown");
    chk(pc_out, exp_pc, "pc after unknown");
    $display("unknown byte %h test finished", b0);
  endtask

  initial begin
    rst_in = 1'b1;
    src_mode_in = 1'b0;
    byte_valid_in = 1'b0;
    byte_in = 8'h00;
    carry_flag_in = 1'b0;
    zero_flag_in = 1'b0;
    pc_load_in = 1'b0;
    pc_load_value_in = '0;
    bit_rd_data_in = 1'b0;
    exp_pc = '0;
    repeat (8) @(negedge clk_in);
    chk(pc_out, 24'h000000, "pc in reset");
    chk(byte_ready_out, 1'b1, "ready in reset");
    chk(busy_out, 1'b0, "busy in reset");
    chk(done_out, 1'b0, "done in reset");
    rst_in = 1'b0;
    pc_load_in = 1'b1;
    pc_load_value_in = 24'h00fff0;
    @(negedge clk_in);
    pc_load_in = 1'b0;
    exp_pc = 24'h00fff0;
    chk(pc_out, exp_pc, "pc load");
    $display("reset and load test finished");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("branch row %0d finished", i);
    end
    bad(1'b0, 1'b0, 8'h00);
    bad(1'b0, 1'b0, OP_EQUAL);
    bad(1'b1, 1'b0, OP_ESCAPE);
    bad(1'b0, 1'b1, 8'h00);
    src_mode_in = 1'b1;
    send(OP_BIT_LONG);
    byte_in = 8'h18;
    #1 chk(unknown_out, 1'b1, "bad sub-opcode");
    @(negedge clk_in);
    chk(busy_out, 1'b0, "idle after bad sub-opcode");
    $display("bad sub-opcode test finished");
    carry_flag_in = 1'b1;
    src_mode_in = 1'b0;
    send(OP_CARRY);
    send(8'h10);
    byte_valid_in = 1'b0;
    rst_in = 1'b1;
    @(negedge clk_in);
    rst_in = 1'b0;
    chk(pc_out, 24'h000000, "pc after mid reset");
    chk(busy_out, 1'b0, "busy after mid reset");
    chk(done_out, 1'b0, "done after mid reset");
    chk(byte_ready_out, 1'b1, "ready after mid reset");
    $display("mid-run reset test finished");
    test_done;
  end

  initial begin
    #100000;
    num_errors++;
    $display("watchdog expired");
    test_done;
  end
endmodule
`default_nettype wire
